// File: rtl/sync_serial_shift_port.sv
// Clocked serial shift port with word buffers and an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "sio_map.svh"
module sync_serial_shift_port (
    input wire logic sys_clk_i, // 200 MHz system clock
    input wire logic nrst_i, // Synchronous reset, active low
    input wire logic [15:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [15:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic sck_i, // Serial clock pin in
    output logic sck_o, // Serial clock pin out
    output logic sck_oe_o, // Serial clock pin drive enable
    input wire logic si_i, // Serial data in
    output logic so_o, // Serial data out
    output logic serial_done_interrupt_o // Burst done pulse
);
    sio_pkg::core_type st_r; // All state
    sio_pkg::core_type st_nxt; // Next state
    logic [1:0] lvl; // Filtered sck and si
    logic ext_clk; // External clock chosen
    logic int_clk; // Valid internal rate chosen
    logic is_rx; // Receive mode
    logic is_nib; // Four-bit words
    logic tick; // Prescaler half period reached
    logic fall_ev; // Leading edge
    logic rise_ev; // Trailing edge
    logic [11:0] half; // Half period minus one
    logic [2:0] last_bit; // Last bit index
    logic wr_go; // Bus write this cycle
    logic [11:0] wr_idx; // Write register index
    logic wr_ok; // Write address mapped
    logic rd_go; // Read accepted this cycle
    logic [11:0] rd_idx; // Read register index
    logic rd_ok; // Read address mapped
    logic [7:0] word; // Shift register after this rise, also the finished word

    // Pins come from outside the clock domain
    pin_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .pin_i({si_i, sck_i}),
        .lvl_o(lvl)
    );

    assign ext_clk = st_r.ctl[`SIO_SCK_HI:`SIO_SCK_LO] == `SIO_SCK_EXT;
    assign int_clk = st_r.ctl[`SIO_SCK_HI:`SIO_SCK_LO] <= `SIO_SCK_MAXINT;
    assign is_rx = st_r.ctl[`SIO_MODE_LO + `SIO_RX_BIT];
    assign is_nib = st_r.ctl[`SIO_MODE_LO + `SIO_NIB_BIT];
    assign last_bit = is_nib ? `SIO_LAST4 : `SIO_LAST8;

    // Rate table; code 110 gives no clock at all
    always_comb
    begin
        case (st_r.ctl[`SIO_SCK_HI:`SIO_SCK_LO])
            3'h0: half = `SIO_HALF_0;
            3'h1: half = `SIO_HALF_1;
            3'h2: half = `SIO_HALF_2;
            3'h3: half = `SIO_HALF_3;
            3'h4: half = `SIO_HALF_4;
            default: half = `SIO_HALF_5;
        endcase
    end

    assign tick = int_clk && st_r.state == sio_pkg::ST_RUN && st_r.pre == half;
    assign fall_ev = ext_clk ? (st_r.ext_prev && !lvl[0]) : (tick && st_r.sck);
    assign rise_ev = ext_clk ? (!st_r.ext_prev && lvl[0]) : (tick && !st_r.sck);

    // Bus decode: aligned word index, upper address bits zero
    assign wr_go = st_r.aw_v && st_r.w_v && !st_r.b_v;
    assign wr_idx = st_r.aw_a[`SIO_IDX_HI:`SIO_IDX_LO];
    assign wr_ok = st_r.aw_a[1:0] == 2'h0 && st_r.aw_a[15:14] == 2'h0 &&
        wr_idx >= `SIO_IDX_BUF0 && wr_idx <= `SIO_IDX_CTL2;
    assign rd_go = s_axi_arvalid && !st_r.r_v;
    assign rd_idx = s_axi_araddr[`SIO_IDX_HI:`SIO_IDX_LO];
    assign rd_ok = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr[15:14] == 2'h0 &&
        rd_idx >= `SIO_IDX_BUF0 && rd_idx <= `SIO_IDX_CTL2;
    assign word = is_nib ? {4'h0, lvl[1], st_r.sh[3:1]} : {lvl[1], st_r.sh[7:1]};

    // Engine first, then bus effects, so software events win
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.irq = 1'b0;
        st_nxt.ext_prev = lvl[0];
        if (st_r.state == sio_pkg::ST_RUN)
        begin
            // Prescaler only counts while shifting
            st_nxt.pre = tick ? 12'h000 : st_r.pre + 12'h001;
            if (tick)
            begin
                st_nxt.sck = !st_r.sck;
            end
            if (fall_ev)
            begin
                st_nxt.so = st_r.sh[0];
            end
            if (rise_ev)
            begin
                // Shift right so the first bit in ends up lowest
                st_nxt.sh = word;
                st_nxt.bitc = st_r.bitc + 3'h1;
                if (st_r.bitc == last_bit)
                begin
                    st_nxt.bitc = 3'h0;
                    st_nxt.sh = st_r.bufs[st_r.idx + 3'h1];
                    st_nxt.idx = st_r.idx + 3'h1;
                    if (is_rx && ext_clk && st_r.full && !st_r.svc)
                    begin
                        // Old burst unread: drop word, cancel
                        st_nxt.state = sio_pkg::ST_IDLE;
                        st_nxt.busy = 1'b0;
                    end
                    else if (is_rx)
                    begin
                        st_nxt.bufs[st_r.idx] = word;
                    end
                    if (st_r.dummy)
                    begin
                        st_nxt.state = sio_pkg::ST_IDLE;
                        st_nxt.busy = 1'b0;
                    end
                    else if (st_nxt.state == sio_pkg::ST_IDLE)
                    begin
                        st_nxt.busy = 1'b0;
                    end
                    else if (st_r.idx == st_r.cnt)
                    begin
                        // Burst complete
                        st_nxt.irq = 1'b1;
                        st_nxt.idx = 3'h0;
                        st_nxt.sh = st_r.bufs[0];
                        st_nxt.svc = 1'b0;
                        st_nxt.full = is_rx;
                        if (!st_r.ctl[`SIO_GO_BIT])
                        begin
                            st_nxt.state = sio_pkg::ST_IDLE;
                            st_nxt.busy = 1'b0;
                        end
                        else if (!ext_clk && !st_r.svc)
                        begin
                            st_nxt.state = sio_pkg::ST_WAIT;
                        end
                        else if (ext_clk && !is_rx && !st_r.svc)
                        begin
                            st_nxt.dummy = 1'b1;
                            st_nxt.sh = `SIO_DUMMY;
                        end
                    end
                    else if (is_rx && !st_r.ctl[`SIO_GO_BIT])
                    begin
                        // Word in progress already stored
                        st_nxt.state = sio_pkg::ST_IDLE;
                        st_nxt.busy = 1'b0;
                    end
                end
            end
        end
        else
        begin
            st_nxt.pre = 12'h000;
            st_nxt.sck = 1'b1;
        end
        // Bus write: either channel order, applied when both held
        if (s_axi_awvalid && !st_r.aw_v)
        begin
            st_nxt.aw_v = 1'b1;
            st_nxt.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.w_v)
        begin
            st_nxt.w_v = 1'b1;
            st_nxt.w_d = s_axi_wdata[7:0];
            st_nxt.w_s = s_axi_wstrb[0];
        end
        if (wr_go)
        begin
            st_nxt.aw_v = 1'b0;
            st_nxt.w_v = 1'b0;
            st_nxt.b_v = 1'b1;
            st_nxt.b_r = wr_ok ? `SIO_RESP_OKAY : `SIO_RESP_SLVERR;
            if (wr_ok && st_r.w_s)
            begin
                if (wr_idx <= `SIO_IDX_BUF7)
                begin
                    // In transmit mode any buffer write counts, used or not
                    st_nxt.bufs[wr_idx[2:0]] = st_r.w_d;
                    st_nxt.svc = !is_rx;
                end
                else if (wr_idx == `SIO_IDX_CTL2)
                begin
                    st_nxt.cnt = st_r.w_d[`SIO_CNT_HI:0];
                end
                else
                begin
                    // Abort never stored: it clears itself
                    st_nxt.ctl = st_r.w_d & `SIO_ABORT_MASK;
                    if (st_r.w_d[`SIO_MODE_HI:`SIO_MODE_LO] !=
                        st_r.ctl[`SIO_MODE_HI:`SIO_MODE_LO])
                    begin
                        st_nxt.bufs = '0;
                    end
                    if (st_r.w_d[`SIO_ABORT_BIT])
                    begin
                        st_nxt.state = sio_pkg::ST_IDLE;
                        st_nxt.busy = 1'b0;
                        st_nxt.sck = 1'b1;
                    end
                    else if (st_r.w_d[`SIO_GO_BIT] && st_r.state == sio_pkg::ST_IDLE &&
                        (st_r.w_d[`SIO_SCK_HI:`SIO_SCK_LO] != 3'h6))
                    begin
                        // Start from the lowest buffer
                        st_nxt.state = sio_pkg::ST_RUN;
                        st_nxt.busy = 1'b1;
                        st_nxt.idx = 3'h0;
                        st_nxt.bitc = 3'h0;
                        st_nxt.sh = st_r.bufs[0];
                        st_nxt.svc = 1'b0;
                        st_nxt.full = 1'b0;
                        st_nxt.dummy = 1'b0;
                    end
                end
            end
        end
        if (st_r.b_v && s_axi_bready)
        begin
            st_nxt.b_v = 1'b0;
        end
        // Bus read; in receive mode any buffer read counts as service
        if (rd_go)
        begin
            st_nxt.r_v = 1'b1;
            st_nxt.r_r = rd_ok ? `SIO_RESP_OKAY : `SIO_RESP_SLVERR;
            st_nxt.r_d = 8'h00;
            if (rd_ok && rd_idx <= `SIO_IDX_BUF7)
            begin
                st_nxt.r_d = st_r.bufs[rd_idx[2:0]];
                st_nxt.svc = st_nxt.svc || is_rx;
            end
            else if (rd_ok && rd_idx == `SIO_IDX_CTL2)
            begin
                st_nxt.r_d[`SIO_STAT_BUSY] = st_r.busy;
                st_nxt.r_d[`SIO_STAT_SHIFT] = st_r.state == sio_pkg::ST_RUN;
            end
        end
        if (st_r.r_v && s_axi_rready)
        begin
            st_nxt.r_v = 1'b0;
        end
        // Wait ends on service or stop
        if (st_nxt.state == sio_pkg::ST_WAIT && st_r.state == sio_pkg::ST_WAIT)
        begin
            if (!st_nxt.ctl[`SIO_GO_BIT])
            begin
                st_nxt.state = sio_pkg::ST_IDLE;
                st_nxt.busy = 1'b0;
            end
            else if (st_nxt.svc)
            begin
                st_nxt.state = sio_pkg::ST_RUN;
                st_nxt.svc = 1'b0;
                st_nxt.sh = st_nxt.bufs[0];
            end
        end
    end

    // Single state register
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            st_r <= '0;
            st_r.ctl <= `SIO_CTL1_RST;
            st_r.cnt <= `SIO_CNT_RST;
            st_r.sck <= 1'b1;
            st_r.so <= 1'b1;
            st_r.ext_prev <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = !st_r.aw_v;
    assign s_axi_wready = !st_r.w_v;
    assign s_axi_bvalid = st_r.b_v;
    assign s_axi_bresp = st_r.b_r;
    assign s_axi_arready = !st_r.r_v;
    assign s_axi_rvalid = st_r.r_v;
    assign s_axi_rresp = st_r.r_r;
    assign s_axi_rdata = {24'h000000, st_r.r_d};
    assign sck_o = st_r.sck;
    assign sck_oe_o = int_clk;
    assign so_o = st_r.so;
    assign serial_done_interrupt_o = st_r.irq;

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_abort_wr;
        wr_go && wr_ok && st_r.w_s && wr_idx == `SIO_IDX_CTL1 && st_r.w_d[`SIO_ABORT_BIT];
    endsequence
    sequence s_mode_wr;
        wr_go && wr_ok && st_r.w_s && wr_idx == `SIO_IDX_CTL1 &&
            st_r.w_d[`SIO_MODE_HI:`SIO_MODE_LO] != st_r.ctl[`SIO_MODE_HI:`SIO_MODE_LO];
    endsequence
    a_ext_no_drive: assert property (ext_clk |-> !sck_oe_o) else $error("ext clock driven");
    a_int_drives: assert property (int_clk |-> sck_oe_o) else $error("int clock undriven");
    a_idle_high: assert property (st_r.state != sio_pkg::ST_RUN |=> sck_o) else $error("sck low idle");
    a_wait_stall: assert property (st_r.state == sio_pkg::ST_WAIT ##1
        st_r.state == sio_pkg::ST_WAIT |-> $stable(sck_o) && sck_o && $stable(st_r.bitc))
        else $error("wait moved");
    a_lsb_out: assert property (st_r.state == sio_pkg::ST_RUN && fall_ev |=> so_o == $past(st_r.sh[0]))
        else $error("not lsb first");
    a_irq_pulse: assert property (serial_done_interrupt_o |=> !serial_done_interrupt_o)
        else $error("irq not a pulse");
    a_abort_ends: assert property (s_abort_wr |=> !st_r.busy && st_r.state == sio_pkg::ST_IDLE)
        else $error("abort ignored");
    a_mode_clears: assert property (s_mode_wr |=> st_r.bufs == '0) else $error("buffers kept");
    a_nib_zero: assert property (is_nib && st_r.state == sio_pkg::ST_RUN |-> st_r.sh[7:4] == 4'h0 ||
        st_r.bitc == 3'h0) else $error("nibble upper set");
endmodule
`default_nettype wire

// File: rtl/sio_map.svh
// Register map, field positions and timing counts of the serial shift port
`ifndef SIO_MAP_SVH
`define SIO_MAP_SVH
// Register indices; byte address is four times the index
`define SIO_IDX_BUF0 12'hF90
`define SIO_IDX_BUF7 12'hF97
`define SIO_IDX_CTL1 12'hF98
`define SIO_IDX_CTL2 12'hF99
`define SIO_IDX_HI 13
`define SIO_IDX_LO 2
// Control word one fields
`define SIO_GO_BIT 7
`define SIO_ABORT_BIT 6
`define SIO_MODE_HI 5
`define SIO_MODE_LO 3
`define SIO_SCK_HI 2
`define SIO_SCK_LO 0
`define SIO_RX_BIT 2
`define SIO_NIB_BIT 1
`define SIO_CTL1_RST 8'h00
`define SIO_ABORT_MASK 8'hBF
// Control word two and status fields
`define SIO_CNT_HI 2
`define SIO_CNT_RST 3'h0
`define SIO_STAT_BUSY 7
`define SIO_STAT_SHIFT 6
// Clock select codes
`define SIO_SCK_EXT 3'h7
`define SIO_SCK_MAXINT 3'h5
// Half serial clock periods minus one, in system clocks
`define SIO_HALF_0 12'hFFF
`define SIO_HALF_1 12'h07F
`define SIO_HALF_2 12'h03F
`define SIO_HALF_3 12'h01F
`define SIO_HALF_4 12'h00F
`define SIO_HALF_5 12'h007
// Last bit index of a word
`define SIO_LAST4 3'h3
`define SIO_LAST8 3'h7
`define SIO_DUMMY 8'hFF
`define SIO_NIB_MASK 8'h0F
// Bus answers
`define SIO_RESP_OKAY 2'h0
`define SIO_RESP_SLVERR 2'h2
`define SIO_SYNC_RST 2'h3
`endif

// File: rtl/sio_pkg.sv
// Types shared by the serial shift port and its pin synchroniser
package sio_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_WAIT = 2'b10
    } state_type;

    typedef logic [7:0][7:0] buf_type;

    typedef struct packed {
        state_type state;
        logic [7:0] ctl;
        logic [2:0] cnt;
        logic busy;
        buf_type bufs;
        logic [7:0] sh;
        logic [2:0] bitc;
        logic [2:0] idx;
        logic [11:0] pre;
        logic sck;
        logic so;
        logic svc;
        logic full;
        logic dummy;
        logic irq;
        logic ext_prev;
        logic aw_v;
        logic [15:0] aw_a;
        logic w_v;
        logic [7:0] w_d;
        logic w_s;
        logic b_v;
        logic [1:0] b_r;
        logic r_v;
        logic [7:0] r_d;
        logic [1:0] r_r;
    } core_type;

    typedef struct packed {
        logic [1:0] f1;
        logic [1:0] f2;
        logic [1:0] f3;
        logic [1:0] lvl;
    } sync_type;
endpackage

// File: rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
`include "sio_map.svh"
module pin_sync (
    input wire logic sys_clk_i, // System clock
    input wire logic nrst_i, // Synchronous reset, active low
    input wire logic [1:0] pin_i, // Raw pins
    output logic [1:0] lvl_o // Filtered levels
);
    sio_pkg::sync_type st_r; // All state
    sio_pkg::sync_type st_nxt; // Next state

    // Level moves only once stages two and three agree
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.f1 = pin_i;
        st_nxt.f2 = st_r.f1;
        st_nxt.f3 = st_r.f2;
        for (int i = 0; i < 2; i++)
        begin
            if (st_r.f2[i] == st_r.f3[i])
            begin
                st_nxt.lvl[i] = st_r.f2[i];
            end
        end
    end

    // Idle-high reset matches a quiet clock pin
    always_ff @(posedge sys_clk_i)
    begin
        if (!nrst_i)
        begin
            st_r <= {4{`SIO_SYNC_RST}};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign lvl_o = st_r.lvl;
endmodule
`default_nettype wire

// File: sim/serial_peer.sv
// Behavioural serial peer on the far side of the shift port
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
    parameter int HALF = 16 // External half period in sys clocks
) (
    input wire logic sys_clk_i, // System clock
    input wire logic sck_i, // Resolved clock pin
    input wire logic so_i, // Device serial out
    output logic si_o, // Device serial in
    output logic ext_sck_o // Clock driven when device is external
);
    logic sck_d = 1'b1; // Previous pin level
    logic [15:0] tx_r = 16'h0000; // Bits to send, LSB first
    logic [15:0] cap_r = 16'h0000; // Bits taken from device
    int sent = 0; // Bits sent
    int got = 0; // Bits captured
    initial si_o = 1'b0;
    initial ext_sck_o = 1'b1; // Stands high outside frames
    // Edge detect on the pin, shift out and capture
    always @(posedge sys_clk_i)
    begin
        sck_d <= sck_i;
        if (sck_d && !sck_i)
        begin
            // Past our bits the line holds no stable value
            si_o <= (sent < 16) ? tx_r[sent] : ~si_o;
            sent <= sent + 1;
        end
        if (!sck_d && sck_i)
        begin
            cap_r <= {so_i, cap_r[15:1]};
            got <= got + 1;
        end
    end
    // Arm a new frame
    task automatic load(input logic [15:0] d);
        tx_r <= d;
        sent <= 0;
        got <= 0;
    endtask
    // Wide pulses so the pin filter never misses one
    task automatic pulses(input int n);
        repeat (n)
        begin
            repeat (HALF) @(posedge sys_clk_i);
            ext_sck_o <= 1'b0;
            repeat (HALF) @(posedge sys_clk_i);
            ext_sck_o <= 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// File: sim/sync_serial_shift_port_tb.sv
// Self-checking bench for the serial shift port over its register bus
`timescale 1ns/1ps
`default_nettype none
module sync_serial_shift_port_tb;
    localparam logic [15:0] BUF0 = 16'h3E40; // First word buffer
    localparam logic [15:0] CTL1 = 16'h3E60; // Go, abort, mode, rate
    localparam logic [15:0] CTL2 = 16'h3E64; // Count, status on read
    localparam int HALVES [6] = '{4096, 128, 64, 32, 16, 8}; // Half periods
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] awaddr = 16'h0000;
    logic [15:0] araddr = 16'h0000;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sck_o, sck_oe, so, si, ext_sck, irq;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, rd_v;
    logic sck_w;
    int bad_count = 0;
    int samples_checked = 0;
    int irq_n = 0;
    int lowc = 0;
    int s;
    // Pin level from whoever drives it
    assign sck_w = sck_oe ? sck_o : ext_sck;
    initial forever #2.5 clk = ~clk;
    // Count burst pulses and low clock cycles
    always @(posedge clk)
    begin
        if (irq) irq_n <= irq_n + 1;
        if (sck_oe && !sck_o) lowc <= lowc + 1;
    end
    sync_serial_shift_port i_sync_serial_shift_port (.sys_clk_i(clk), .nrst_i(nrst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sck_i(sck_w), .sck_o(sck_o),
        .sck_oe_o(sck_oe), .si_i(si), .so_o(so), .serial_done_interrupt_o(irq));
    serial_peer i_serial_peer (.sys_clk_i(clk), .sck_i(sck_w), .so_i(so), .si_o(si),
        .ext_sck_o(ext_sck));
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask
    // A hung wait counts as a mismatch
    task automatic tmo();
        bad_count++;
        complete_run();
    endtask
    // Write one byte; address and data released as each is taken
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        logic ta, tw, tb;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 200; n++)
        begin
            @(negedge clk);
            ta = awready;
            tw = wready;
            tb = bvalid;
            rsp = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb)
            begin
                bready <= 1'b0;
                break;
            end
        end
        if (n == 200) tmo();
        chk(32'(rsp), 32'(er));
    endtask
    // Read one word into rd_v
    task automatic rd(input logic [15:0] a, input logic [1:0] er);
        int n;
        logic ta, tr;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 200; n++)
        begin
            @(negedge clk);
            ta = arready;
            tr = rvalid;
            rsp = rresp;
            rd_v = rdata;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tr)
            begin
                rready <= 1'b0;
                break;
            end
        end
        if (n == 200) tmo();
        chk(32'(rsp), 32'(er));
    endtask
    // Wait for a burst end pulse after the count st
    task automatic wirq(input int st);
        int n;
        for (n = 0; n < 40000 && irq_n <= st; n++) @(posedge clk);
        if (n == 40000) tmo();
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        wr(16'h0104, 8'h00, 2'h2); // Unmapped write refused
        rd(16'h0100, 2'h2); // Unmapped read refused
        rd(CTL2, 2'h0);
        chk(rd_v, 32'h00000000); // Idle after reset
        // Two-word internal transmit, stall, then abort
        wr(CTL1, 8'h45, 2'h0);
        wr(CTL2, 8'h01, 2'h0);
        wr(BUF0, 8'hA5, 2'h0);
        wr(BUF0 + 16'h0004, 8'h3C, 2'h0);
        i_serial_peer.load(16'h0000);
        s = irq_n;
        wr(CTL1, 8'h85, 2'h0);
        wirq(s);
        chk(32'(i_serial_peer.cap_r), 32'h00003CA5);
        chk(32'(i_serial_peer.got), 32'd16);
        repeat (200) @(posedge clk);
        chk(32'(i_serial_peer.got), 32'd16);
        chk(32'(sck_o), 32'h00000001);
        rd(CTL2, 2'h0);
        chk(rd_v & 32'h00000080, 32'h00000080);
        // Writing an unused buffer still releases the wait
        s = irq_n;
        wr(BUF0 + 16'h001C, 8'h00, 2'h0);
        wirq(s);
        chk(32'(i_serial_peer.got), 32'd32);
        wr(CTL1, 8'h45, 2'h0);
        rd(CTL2, 2'h0);
        chk(rd_v & 32'h00000080, 32'h00000000);
        // Every internal rate, one 4-bit word
        wr(CTL2, 8'h00, 2'h0);
        for (int r = 0; r < 6; r++)
        begin
            wr(CTL1, 8'h50 | 8'(r), 2'h0);
            wr(BUF0, 8'hF6, 2'h0);
            chk(32'(sck_oe), 32'h00000001);
            i_serial_peer.load(16'h0000);
            lowc <= 0;
            s = irq_n;
            wr(CTL1, 8'h90 | 8'(r), 2'h0);
            wirq(s);
            chk(32'(lowc), 32'(4 * HALVES[r]));
            chk(32'(i_serial_peer.cap_r[15:12]), 32'h00000006);
            wr(CTL1, 8'h50 | 8'(r), 2'h0);
        end
        // Internal 4-bit receive, upper nibble zero
        wr(CTL1, 8'h75, 2'h0);
        i_serial_peer.load(16'hA5FD);
        s = irq_n;
        wr(CTL1, 8'hB5, 2'h0);
        wirq(s);
        rd(BUF0, 2'h0);
        chk(rd_v, 32'h0000000D);
        wr(CTL1, 8'h75, 2'h0);
        // External 8-bit receive
        wr(CTL1, 8'h6F, 2'h0);
        chk(32'(sck_oe), 32'h00000000);
        i_serial_peer.load(16'h0096);
        wr(CTL1, 8'hAF, 2'h0);
        s = irq_n;
        i_serial_peer.pulses(8);
        wirq(s);
        rd(BUF0, 2'h0);
        chk(rd_v, 32'h00000096);
        wr(CTL1, 8'h6F, 2'h0);
        // Mode change wipes the buffers
        wr(BUF0 + 16'h000C, 8'h55, 2'h0);
        rd(BUF0 + 16'h000C, 2'h0);
        chk(rd_v, 32'h00000055);
        // Byte lane zero off: the write answers but stores nothing
        wstrb <= 4'hE;
        wr(BUF0 + 16'h000C, 8'hAA, 2'h0);
        wstrb <= 4'hF;
        rd(BUF0 + 16'h000C, 2'h0);
        chk(rd_v, 32'h00000055);
        wr(CTL1, 8'h45, 2'h0);
        rd(BUF0 + 16'h000C, 2'h0);
        chk(rd_v, 32'h00000000);
        complete_run();
    end
endmodule
`default_nettype wire
